// [testbench/event_source_model.sv]
// Peripheral event sources: one-cycle pulses on request
module event_source_model (
   input wire logic                                 core_clk,
   input wire logic                                 rst,
   input wire logic                                 go,
   input wire event_manager_pkg::peripheral_events_t req,
   output event_manager_pkg::peripheral_events_t    periph_events
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pulses only: a held level would look like a repeated event
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         periph_events <= '0;
      else
         periph_events <= go ? req : '0;
   end
endmodule

// [testbench/second_level_event_monitor.sv]
// Port-level assertions for the second-level event manager
module second_level_event_monitor (
   input wire logic                                 core_clk,
   input wire logic                                 rst,
   input wire logic                                 psel,
   input wire logic                                 penable,
   input wire logic                                 pwrite,
   input wire logic                                 pready,
   input wire logic                                 pslverr,
   input wire event_manager_pkg::peripheral_events_t periph_events,
   input wire logic                                 main_system_clock_on_crystal,
   input wire logic                                 crystal_failure_detected,
   input wire event_manager_pkg::bus_access_t       bus_access,
   input wire logic [16:0]                          top_req,
   input wire logic [16:0]                          core_irq,
   input wire logic                                 hard_fault,
   input wire logic                                 main_system_clock_select_rc
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   chk_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   chk_err_with_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("pslverr outside access phase");
   chk_unused_top_zero: assert property ((top_req & ~17'h00863) == 17'h00000)
      else $error("request on a top bit with no bank");
   chk_irq_needs_req: assert property ((core_irq & ~$past(top_req)) == 17'h00000)
      else $error("core request without merged request");
   // Sticky: falls only after a register write
   chk_req_held: assert property ((($past(top_req) & ~top_req) != 17'h00000) |->
      ($past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2)))
      else $error("request dropped without a clearing write");
   chk_req_cause: assert property ((($past(top_req) & ~top_req) == 17'h00000 && top_req != $past(top_req)) |->
      ($past(|periph_events) || $past(|periph_events, 2) || $past(psel && penable && pwrite, 2)
       || $past(psel && penable && pwrite)))
      else $error("request rose without event or enable write");
   chk_rc_switch_cause: assert property ($rose(main_system_clock_select_rc) |->
      $past(main_system_clock_on_crystal && crystal_failure_detected))
      else $error("clock switched without crystal failure");
   chk_rc_sticky: assert property (main_system_clock_select_rc |=> main_system_clock_select_rc)
      else $error("clock switch latch dropped");
   chk_hard_fault_cause: assert property (hard_fault |-> $past(bus_access.valid))
      else $error("hard fault without bus access");
endmodule

bind second_level_event_manager second_level_event_monitor monitor_i (
   .core_clk                 (core_clk),
   .rst                      (rst),
   .psel                     (psel),
   .penable                  (penable),
   .pwrite                   (pwrite),
   .pready                   (pready),
   .pslverr                  (pslverr),
   .periph_events            (periph_events),
   .main_system_clock_on_crystal        (main_system_clock_on_crystal),
   .crystal_failure_detected (crystal_failure_detected),
   .bus_access               (bus_access),
   .top_req                  (top_req),
   .core_irq                 (core_irq),
   .hard_fault               (hard_fault),
   .main_system_clock_select_rc         (main_system_clock_select_rc)
);

// [testbench/tb_second_level_event_manager.sv]
// Self-checking bench for the second-level event manager
module tb_second_level_event_manager;
   timeunit 1ns;
   timeprecision 1ps;
   logic                                 core_clk, rst, psel, penable, pwrite, pready, pslverr, err, go;
   logic                                 on_xtal, xtal_fail, wd_active, wd_restart, nmi_req, hard_fault, clk_rc;
   logic [11:0]                          paddr;
   logic [31:0]                          pwdata, prdata, rd, d;
   logic [16:0]                          top_req, core_irq;
   event_manager_pkg::peripheral_events_t ev, req;
   event_manager_pkg::bus_access_t       bus_access;
   int                                   n_fail, compares, b, k, t;

   second_level_event_manager #(.WDOG_LOW_WATER_CYCLES(20)) second_level_event_manager_i (
      .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_events(ev),
      .main_system_clock_on_crystal(on_xtal), .crystal_failure_detected(xtal_fail), .watchdog_active(wd_active),
      .watchdog_restart(wd_restart), .bus_access(bus_access), .top_req(top_req), .core_irq(core_irq),
      .nmi_req(nmi_req), .hard_fault(hard_fault), .main_system_clock_select_rc(clk_rc));
   event_source_model event_source_model_i (.core_clk(core_clk), .rst(rst), .go(go), .req(req), .periph_events(ev));

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic end_of_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         n_fail++;
      end
   endtask

   // Entered just after a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         n_fail++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic fire(input event_manager_pkg::peripheral_events_t e);
      req <= e;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask

   function automatic logic [14:0] mask(input int bank);
      case (bank)
         0, 1: return event_manager_pkg::MASK_TIMER;
         2: return event_manager_pkg::MASK_SERIAL1;
         3: return event_manager_pkg::MASK_SERIAL2;
         4: return event_manager_pkg::MASK_ADC;
         default: return event_manager_pkg::MASK_NMI;
      endcase
   endfunction

   function automatic int top_bit(input int bank);
      case (bank)
         0, 1: return bank;
         2: return 5;
         3: return 6;
         default: return 11;
      endcase
   endfunction

   function automatic event_manager_pkg::peripheral_events_t mk(input int bank, input int bit_n);
      event_manager_pkg::peripheral_events_t e;
      e = '0;
      case (bank)
         0: e.timer1[bit_n] = 1'b1;
         1: e.timer2[bit_n] = 1'b1;
         2: e.serial1[bit_n] = 1'b1;
         3: e.serial2[bit_n] = 1'b1;
         default: e.adc[bit_n] = 1'b1;
      endcase
      return e;
   endfunction

   initial
   begin
      #500us;
      n_fail++;
      end_of_test();
   end

   initial
   begin
      {rst, psel, penable, pwrite, paddr, pwdata, go, req} = '0;
      {on_xtal, xtal_fail, wd_active, wd_restart, bus_access} = '0;
      rst = 1'b1;
      d = $urandom(32'hb7c53c80);
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      for (b = 0; b < 6; b++)
      begin
         apb(1'b0, 12'(event_manager_pkg::FLAG_BASE + 4 * b), 32'h0);
         check("flag reset", rd, 32'h0);
         apb(1'b0, 12'(event_manager_pkg::ENABLE_BASE + 4 * b), 32'h0);
         check("enable reset", rd, 32'h0);
         d = $urandom;
         apb(1'b1, 12'(event_manager_pkg::ENABLE_BASE + 4 * b), d);
         apb(1'b0, 12'(event_manager_pkg::ENABLE_BASE + 4 * b), 32'h0);
         check("enable readback", rd, {17'h0, d[14:0] & mask(b)});
         apb(1'b1, 12'(event_manager_pkg::ENABLE_BASE + 4 * b), 32'h0);
      end
      apb(1'b0, event_manager_pkg::MISS_OFF, 32'h0);
      check("missed reset", rd, 32'h0);
      apb(1'b0, 12'hffc, 32'h0);
      check("unmapped error", {31'h0, err}, 32'h1);
      $display("test reset_and_enables done");
      for (b = 0; b < 5; b++)
      begin
         t = top_bit(b);
         do
            k = $urandom_range(14, 0);
         while (((mask(b) >> k) & 15'h1) == 15'h0);
         fire(mk(b, k));
         check("masked request", top_req[t], 32'h0);
         apb(1'b0, 12'(event_manager_pkg::FLAG_BASE + 4 * b), 32'h0);
         check("flag set", rd, 32'h1 << k);
         apb(1'b1, 12'(event_manager_pkg::ENABLE_BASE + 4 * b), 32'h1 << k);
         apb(1'b1, event_manager_pkg::TOP_ENABLE_OFF, 32'h1 << t);
         repeat (2) @(posedge core_clk);
         check("late enable request", top_req, 17'h1 << t);
         check("core request", core_irq, 17'h1 << t);
         fire(mk(b, k));
         apb(1'b0, event_manager_pkg::MISS_OFF, 32'h0);
         check("missed bit", rd, 32'h1 << t);
         apb(1'b1, 12'(event_manager_pkg::FLAG_BASE + 4 * b), 32'h0);
         check("write zero keeps", top_req[t], 32'h1);
         apb(1'b1, 12'(event_manager_pkg::FLAG_BASE + 4 * b), 32'h1 << k);
         repeat (2) @(posedge core_clk);
         check("cleared request", top_req, 17'h0);
         apb(1'b1, event_manager_pkg::MISS_OFF, 32'h1 << t);
         apb(1'b0, event_manager_pkg::MISS_OFF, 32'h0);
         check("missed cleared", rd, 32'h0);
         apb(1'b1, 12'(event_manager_pkg::ENABLE_BASE + 4 * b), 32'h0);
      end
      $display("test peripheral_events done");
      on_xtal <= 1'b1;
      xtal_fail <= 1'b1;
      @(posedge core_clk);
      xtal_fail <= 1'b0;
      repeat (3) @(posedge core_clk);
      check("clock to rc", clk_rc, 32'h1);
      apb(1'b1, 12'(event_manager_pkg::ENABLE_BASE + 20), 32'h3);
      @(posedge core_clk);
      check("crystal nmi", nmi_req, 32'h1);
      apb(1'b0, event_manager_pkg::STATUS_OFF, 32'h0);
      check("status rc", rd[0], 32'h1);
      apb(1'b1, 12'(event_manager_pkg::FLAG_BASE + 20), 32'h1);
      @(posedge core_clk);
      check("nmi cleared", nmi_req, 32'h0);
      wd_active <= 1'b1;
      repeat (30) @(posedge core_clk);
      check("watchdog nmi", nmi_req, 32'h1);
      apb(1'b0, 12'(event_manager_pkg::FLAG_BASE + 20), 32'h0);
      check("watchdog flag", rd, 32'h2);
      wd_active <= 1'b0;
      $display("test nmi_sources done");
      bus_access <= '{1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      @(posedge core_clk);
      bus_access.valid <= 1'b0;
      apb(1'b0, event_manager_pkg::AUX_FAULT_OFF, 32'h0);
      check("size and unmapped", rd, 32'h5);
      bus_access <= '{1'b1, 1'b1, 1'b0, 2'h2, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      @(posedge core_clk);
      bus_access.valid <= 1'b0;
      @(posedge core_clk);
      check("hard fault", hard_fault, 32'h1);
      apb(1'b0, event_manager_pkg::AUX_FAULT_OFF, 32'h0);
      check("protect and missed", rd, 32'hf);
      apb(1'b1, event_manager_pkg::AUX_FAULT_OFF, 32'hf);
      apb(1'b0, event_manager_pkg::AUX_FAULT_OFF, 32'h0);
      check("fault cleared", rd, 32'h0);
      $display("test bus_faults done");
      end_of_test();
   end
endmodule

// [verilog/event_flag_bank.sv]
// Sticky flag, enable mask and merged request for one peripheral
module event_flag_bank #(
   parameter logic [14:0] VALID = 15'h7fff
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [14:0] events,
   input  wire logic        flag_wr,
   input  wire logic        enable_wr,
   input  wire logic [14:0] wdata,
   output logic [14:0]      flags,
   output logic [14:0]      enables,
   output logic             req,
   output logic             miss
);
   event_manager_pkg::bank_state_t s_reg;
   event_manager_pkg::bank_state_t s_next;
   logic [14:0]                    clr;
   logic [14:0]                    ev;

   always_comb
   begin
      s_next = s_reg;
      ev     = events & VALID;
      clr    = flag_wr ? wdata : 15'h0000;
      // Event is ORed in after the clear so a coincident event survives
      s_next.flags = ((s_reg.flags & ~clr) | ev) & VALID;
      if (enable_wr)
      begin
         s_next.enables = wdata & VALID;
      end
      s_next.req = |(s_next.flags & s_next.enables);
      miss       = |(ev & s_reg.flags & s_reg.enables & ~clr);
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign flags   = s_reg.flags;
   assign enables = s_reg.enables;
   assign req     = s_reg.req;
endmodule

// [verilog/event_manager_pkg.sv]
// Shared constants, register map and carrier types for the second-level event manager
package event_manager_pkg;

   localparam int NUM_BANKS = 6;
   localparam int BANK_W    = 15;
   localparam int TOP_W     = 17;
   localparam int ADDR_W    = 12;

   // Bank order inside the flag bank array
   localparam int BANK_TIMER1  = 0;
   localparam int BANK_TIMER2  = 1;
   localparam int BANK_SERIAL1 = 2;
   localparam int BANK_SERIAL2 = 3;
   localparam int BANK_ADC     = 4;
   localparam int BANK_NMI     = 5;

   // Top-level request positions, also the missed-event bit positions; the NMI bank has a missed-event bit only
   localparam int TOP_BIT_TIMER1  = 0;
   localparam int TOP_BIT_TIMER2  = 1;
   localparam int TOP_BIT_SERIAL1 = 5;
   localparam int TOP_BIT_SERIAL2 = 6;
   localparam int TOP_BIT_ADC     = 11;
   localparam int MISS_BIT_NMI    = 17;

   localparam logic [BANK_W-1:0] MASK_TIMER   = 15'h005f;
   localparam logic [BANK_W-1:0] MASK_SERIAL1 = 15'h7fff;
   localparam logic [BANK_W-1:0] MASK_SERIAL2 = 15'h1fff;
   localparam logic [BANK_W-1:0] MASK_ADC     = 15'h001f;
   localparam logic [BANK_W-1:0] MASK_NMI     = 15'h0003;
   localparam int NMI_BIT_CRYSTAL  = 0;
   localparam int NMI_BIT_WATCHDOG = 1;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] FLAG_BASE      = 12'h000;
   localparam logic [ADDR_W-1:0] ENABLE_BASE    = 12'h020;
   localparam logic [ADDR_W-1:0] MISS_OFF       = 12'h040;
   localparam logic [ADDR_W-1:0] AUX_FAULT_OFF  = 12'h044;
   localparam logic [ADDR_W-1:0] TOP_ENABLE_OFF = 12'h048;
   localparam logic [ADDR_W-1:0] STATUS_OFF     = 12'h04c;
   localparam logic [ADDR_W-1:0] BANK_SPAN      = 12'h018;

   // Auxiliary fault status bits
   localparam int FAULT_SIZE     = 0;
   localparam int FAULT_PROTECT  = 1;
   localparam int FAULT_UNMAPPED = 2;
   localparam int FAULT_MISSED   = 3;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // Timing
   localparam longint CLK_HZ               = 40_000_000;
   localparam longint WDOG_LOW_WATER_MS    = 1792;
   localparam longint WDOG_LOW_WATER_CYCLES = WDOG_LOW_WATER_MS * CLK_HZ / 1000;
   localparam int     WDOG_CNT_W           = 27;

   typedef struct packed {
      logic [6:0]  timer1;
      logic [6:0]  timer2;
      logic [14:0] serial1;
      logic [12:0] serial2;
      logic [4:0]  adc;
   } peripheral_events_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic       privileged;
      logic [1:0] size;
      logic [1:0] addr_low;
      logic       apb_target;
      logic       system_target;
      logic       protected_ram;
      logic       beyond_last_reg;
      logic       beyond_mem_top;
   } bus_access_t;

   typedef struct packed {
      logic [BANK_W-1:0] flags;
      logic [BANK_W-1:0] enables;
      logic              req;
   } bank_state_t;

   typedef struct packed {
      logic [WDOG_CNT_W-1:0] count;
      logic                  fired;
      logic                  event_out;
   } wdog_state_t;

endpackage

// [verilog/second_level_event_manager.sv]
// Second-level event manager: flag banks, missed events, NMI sources, bus fault status, APB slave
module second_level_event_manager #(
   parameter longint WDOG_LOW_WATER_CYCLES = event_manager_pkg::WDOG_LOW_WATER_CYCLES
) (
   input  wire logic                                core_clk,
   input  wire logic                                rst,
   input  wire logic [11:0]                         paddr,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [31:0]                         pwdata,
   output logic [31:0]                              prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   input  wire event_manager_pkg::peripheral_events_t periph_events,
   input  wire logic                                main_system_clock_on_crystal,
   input  wire logic                                crystal_failure_detected,
   input  wire logic                                watchdog_active,
   input  wire logic                                watchdog_restart,
   input  wire event_manager_pkg::bus_access_t      bus_access,
   output logic [16:0]                              top_req,
   output logic [16:0]                              core_irq,
   output logic                                     nmi_req,
   output logic                                     hard_fault,
   output logic                                     main_system_clock_select_rc
);

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic [31:0] miss;
      logic [3:0]  fault;
      logic [16:0] top_enable;
      logic [16:0] core_irq;
      logic        hard_fault;
      logic        clk_rc;
      logic        xtal_event;
   } core_state_t;

   core_state_t s_reg;
   core_state_t s_next;

   logic [14:0] bank_events  [event_manager_pkg::NUM_BANKS];
   logic [14:0] bank_flags   [event_manager_pkg::NUM_BANKS];
   logic [14:0] bank_enables [event_manager_pkg::NUM_BANKS];
   logic        bank_req     [event_manager_pkg::NUM_BANKS];
   logic        bank_miss    [event_manager_pkg::NUM_BANKS];
   logic        flag_wr      [event_manager_pkg::NUM_BANKS];
   logic        enable_wr    [event_manager_pkg::NUM_BANKS];
   logic        wdog_low_water;
   logic [16:0] top_req_now;

   // Bank lookup tables
   function automatic logic [14:0] bank_mask(input int b);
      case (b)
         event_manager_pkg::BANK_TIMER1:  return event_manager_pkg::MASK_TIMER;
         event_manager_pkg::BANK_TIMER2:  return event_manager_pkg::MASK_TIMER;
         event_manager_pkg::BANK_SERIAL1: return event_manager_pkg::MASK_SERIAL1;
         event_manager_pkg::BANK_SERIAL2: return event_manager_pkg::MASK_SERIAL2;
         event_manager_pkg::BANK_ADC:     return event_manager_pkg::MASK_ADC;
         default:                         return event_manager_pkg::MASK_NMI;
      endcase
   endfunction

   function automatic int bank_top_bit(input int b);
      case (b)
         event_manager_pkg::BANK_TIMER1:  return event_manager_pkg::TOP_BIT_TIMER1;
         event_manager_pkg::BANK_TIMER2:  return event_manager_pkg::TOP_BIT_TIMER2;
         event_manager_pkg::BANK_SERIAL1: return event_manager_pkg::TOP_BIT_SERIAL1;
         event_manager_pkg::BANK_SERIAL2: return event_manager_pkg::TOP_BIT_SERIAL2;
         event_manager_pkg::BANK_ADC:     return event_manager_pkg::TOP_BIT_ADC;
         default:                         return event_manager_pkg::MISS_BIT_NMI;
      endcase
   endfunction

   // Word-aligned hit inside a block of per-bank registers
   function automatic logic bank_hit(input logic [11:0] a, input logic [11:0] base);
      return (a >= base) && (a < base + event_manager_pkg::BANK_SPAN) && (a[1:0] == 2'h0);
   endfunction

   function automatic int bank_index(input logic [11:0] a, input logic [11:0] base);
      logic [11:0] d;
      d = a - base;
      return int'(d[11:2]);
   endfunction

   // Event routing into the banks
   always_comb
   begin
      bank_events[event_manager_pkg::BANK_TIMER1]  = {8'h00, periph_events.timer1};
      bank_events[event_manager_pkg::BANK_TIMER2]  = {8'h00, periph_events.timer2};
      bank_events[event_manager_pkg::BANK_SERIAL1] = periph_events.serial1;
      bank_events[event_manager_pkg::BANK_SERIAL2] = {2'h0, periph_events.serial2};
      bank_events[event_manager_pkg::BANK_ADC]     = {10'h000, periph_events.adc};
      bank_events[event_manager_pkg::BANK_NMI]     = 15'h0000;
      bank_events[event_manager_pkg::BANK_NMI][event_manager_pkg::NMI_BIT_CRYSTAL]  = s_reg.xtal_event;
      bank_events[event_manager_pkg::BANK_NMI][event_manager_pkg::NMI_BIT_WATCHDOG] = wdog_low_water;
   end

   genvar g;
   generate
      for (g = 0; g < event_manager_pkg::NUM_BANKS; g++)
      begin : gen_bank
         event_flag_bank #(
            .VALID (bank_mask(g))
         ) u_bank (
            .core_clk  (core_clk),
            .rst       (rst),
            .events    (bank_events[g]),
            .flag_wr   (flag_wr[g]),
            .enable_wr (enable_wr[g]),
            .wdata     (pwdata[14:0]),
            .flags     (bank_flags[g]),
            .enables   (bank_enables[g]),
            .req       (bank_req[g]),
            .miss      (bank_miss[g])
         );
      end
   endgenerate

   watchdog_low_water #(
      .LOW_WATER_CYCLES (WDOG_LOW_WATER_CYCLES)
   ) u_wdog (
      .core_clk  (core_clk),
      .rst       (rst),
      .active    (watchdog_active),
      .restart   (watchdog_restart),
      .low_water (wdog_low_water)
   );

   always_comb
   begin
      logic        setup;
      logic        wr;
      logic [31:0] miss_set;
      logic [31:0] wclr;
      logic        f_size;
      logic        f_prot;
      logic        f_unmap;
      logic        f_any;
      logic        f_second;
      logic [3:0]  f_set;
      setup    = 1'b0;
      wr       = 1'b0;
      miss_set = 32'h0000_0000;
      wclr     = 32'h0000_0000;
      f_size   = 1'b0;
      f_prot   = 1'b0;
      f_unmap  = 1'b0;
      f_any    = 1'b0;
      f_second = 1'b0;
      f_set    = 4'h0;
      s_next   = s_reg;

      // APB: data captured in setup, answer in first access cycle
      setup          = psel && !penable;
      wr             = psel && penable && s_reg.pready && pwrite && !s_reg.pslverr;
      s_next.pready  = setup;
      s_next.pslverr = 1'b0;
      if (setup)
      begin
         s_next.prdata = 32'h0000_0000;
         if (bank_hit(paddr, event_manager_pkg::FLAG_BASE))
         begin
            s_next.prdata = {17'h00000, bank_flags[bank_index(paddr, event_manager_pkg::FLAG_BASE)]};
         end
         else if (bank_hit(paddr, event_manager_pkg::ENABLE_BASE))
         begin
            s_next.prdata = {17'h00000, bank_enables[bank_index(paddr, event_manager_pkg::ENABLE_BASE)]};
         end
         else if (paddr == event_manager_pkg::MISS_OFF)
         begin
            s_next.prdata = s_reg.miss;
         end
         else if (paddr == event_manager_pkg::AUX_FAULT_OFF)
         begin
            s_next.prdata = {28'h0000000, s_reg.fault};
         end
         else if (paddr == event_manager_pkg::TOP_ENABLE_OFF)
         begin
            s_next.prdata = {15'h0000, s_reg.top_enable};
         end
         else if (paddr == event_manager_pkg::STATUS_OFF)
         begin
            s_next.prdata = {13'h0000, top_req_now, 1'b0, s_reg.clk_rc};
         end
         else
         begin
            s_next.pslverr = 1'b1;
         end
      end

      for (int b = 0; b < event_manager_pkg::NUM_BANKS; b++)
      begin
         flag_wr[b]   = wr && bank_hit(paddr, event_manager_pkg::FLAG_BASE)
                        && (bank_index(paddr, event_manager_pkg::FLAG_BASE) == b);
         enable_wr[b] = wr && bank_hit(paddr, event_manager_pkg::ENABLE_BASE)
                        && (bank_index(paddr, event_manager_pkg::ENABLE_BASE) == b);
         if (bank_miss[b])
         begin
            miss_set[bank_top_bit(b)] = 1'b1;
         end
      end

      // Missed events: set wins over a write-one clear
      if (wr && (paddr == event_manager_pkg::MISS_OFF))
      begin
         wclr = pwdata;
      end
      s_next.miss = (s_reg.miss & ~wclr) | miss_set;

      if (wr && (paddr == event_manager_pkg::TOP_ENABLE_OFF))
      begin
         s_next.top_enable = pwdata[16:0];
      end
      // Pending level reaches the core as soon as its enable is on
      s_next.core_irq = top_req_now & s_next.top_enable;

      // Bus fault causes; one access may raise several
      if (bus_access.valid)
      begin
         f_size  = (bus_access.apb_target && (bus_access.size != event_manager_pkg::SIZE_WORD))
                   || ((bus_access.size == event_manager_pkg::SIZE_WORD) && (bus_access.addr_low != 2'h0));
         f_prot  = bus_access.write && !bus_access.privileged
                   && (bus_access.system_target || bus_access.protected_ram);
         f_unmap = bus_access.beyond_last_reg || bus_access.beyond_mem_top;
      end
      f_any    = f_size || f_prot || f_unmap;
      // A fault while an earlier cause is still recorded counts as a second fault
      f_second = f_any && (s_reg.fault != 4'h0);
      f_set[event_manager_pkg::FAULT_SIZE]     = f_size;
      f_set[event_manager_pkg::FAULT_PROTECT]  = f_prot;
      f_set[event_manager_pkg::FAULT_UNMAPPED] = f_unmap;
      f_set[event_manager_pkg::FAULT_MISSED]   = f_second;
      if (wr && (paddr == event_manager_pkg::AUX_FAULT_OFF))
      begin
         s_next.fault = (s_reg.fault & ~pwdata[3:0]) | f_set;
      end
      else
      begin
         s_next.fault = s_reg.fault | f_set;
      end
      s_next.hard_fault = f_second;

      // Switch to the RC clock and raise the crystal event in the same cycle
      s_next.xtal_event = 1'b0;
      if (main_system_clock_on_crystal && crystal_failure_detected && !s_reg.clk_rc)
      begin
         s_next.clk_rc     = 1'b1;
         s_next.xtal_event = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   always_comb
   begin
      top_req_now = 17'h00000;
      for (int b = 0; b < event_manager_pkg::BANK_NMI; b++)
      begin
         top_req_now[bank_top_bit(b)] = bank_req[b];
      end
   end

   assign prdata           = s_reg.prdata;
   assign pready           = s_reg.pready;
   assign pslverr          = s_reg.pslverr;
   assign top_req          = top_req_now;
   assign core_irq         = s_reg.core_irq;
   assign nmi_req          = bank_req[event_manager_pkg::BANK_NMI];
   assign hard_fault       = s_reg.hard_fault;
   assign main_system_clock_select_rc = s_reg.clk_rc;

endmodule

// [verilog/watchdog_low_water.sv]
// Low-water timer: one event when the watchdog has gone unrestarted too long
module watchdog_low_water #(
   parameter longint LOW_WATER_CYCLES = event_manager_pkg::WDOG_LOW_WATER_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic active,
   input  wire logic restart,
   output logic      low_water
);
   event_manager_pkg::wdog_state_t s_reg;
   event_manager_pkg::wdog_state_t s_next;

   always_comb
   begin
      s_next           = s_reg;
      s_next.event_out = 1'b0;
      if (!active || restart)
      begin
         s_next.count = '0;
         s_next.fired = 1'b0;
      end
      else if (!s_reg.fired)
      begin
         if (s_reg.count == event_manager_pkg::WDOG_CNT_W'(LOW_WATER_CYCLES - 1))
         begin
            // Fires once; stays quiet until the next restart or until active drops
            s_next.fired     = 1'b1;
            s_next.event_out = 1'b1;
         end
         else
         begin
            s_next.count = s_reg.count + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign low_water = s_reg.event_out;
endmodule
